/* rtl/cdr_pkg.sv */
// Shared constants and types for the coil driver register bank
package cdr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_CUR_HIGH = 8'h03;
    localparam logic [7:0] ADDR_CUR_LOW = 8'h04;
    localparam logic [7:0] ADDR_FAULT = 8'h05;

    // Control register fields
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_RING_EN_BIT = 1;

    // Coil current code layout
    localparam int CODE_W = 10;
    localparam int CUR_HIGH_W = 2;
    localparam int CUR_LOW_W = 8;

    // Fault flag positions
    localparam int FAULT_COUNT = 5;
    localparam int FLT_OVERCURRENT = 0;
    localparam int FLT_UNDERVOLT = 1;
    localparam int FLT_COIL_OPEN = 2;
    localparam int FLT_COIL_SHORT = 3;
    localparam int FLT_THERMAL = 4;

    // Reset values
    localparam logic RST_RING_EN = 1'b1;
    localparam logic [CUR_HIGH_W-1:0] RST_CUR_HIGH = 2'h0;
    localparam logic [CUR_LOW_W-1:0] RST_CUR_LOW = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE = 10'h000;
    localparam logic [FAULT_COUNT-1:0] RST_FLAGS = 5'h00;
    localparam logic [7:0] RST_READ = 8'h00;

    // Output current scale, microamps per code step
    localparam int CURRENT_W = 17;
    localparam logic [CURRENT_W-1:0] STEP_UA = 17'h00064;

    typedef enum logic {
        CDR_STANDBY,
        CDR_ACTIVE
    } cdr_mode_t;

endpackage

/* rtl/cdr_sync.sv */
// Two-stage synchroniser for the asynchronous fault pins
`timescale 1ns/1ps
module cdr_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } cdr_sync_state_t;

    cdr_sync_state_t s;
    cdr_sync_state_t next_s;

    // Stage one feeds only stage two
    always_comb begin
        next_s.stage1 = asyncIn;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign syncOut = s.stage2;

endmodule // cdr_sync

/* rtl/cdr_fault_flags.sv */
// Sticky fault flags with clear on activation
`timescale 1ns/1ps
module cdr_fault_flags (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Live fault levels and clear
    input wire logic [cdr_pkg::FAULT_COUNT-1:0] faultNow,
    input wire logic clearAll,
    // Held flags
    output logic [cdr_pkg::FAULT_COUNT-1:0] flags
);
    import cdr_pkg::*;

    typedef struct packed {
        logic [FAULT_COUNT-1:0] flags;
    } cdr_flags_state_t;

    cdr_flags_state_t s;
    cdr_flags_state_t next_s;

    // A fault present in the clearing cycle still lands
    always_comb begin
        next_s = s;
        if (clearAll) begin
            next_s.flags = RST_FLAGS;
        end
        next_s.flags = next_s.flags | faultNow;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s.flags <= RST_FLAGS;
        end else begin
            s <= next_s;
        end
    end

    assign flags = s.flags;

    AST_FLAG_CLEARS: assert property (
        @(posedge sys_clk) disable iff (rst)
        clearAll && (faultNow == '0) |=> flags == '0)
        else $error("fault flags not cleared on activation");

    AST_FLAG_STICKS: assert property (
        @(posedge sys_clk) disable iff (rst)
        (faultNow != '0) |=> ((flags & $past(faultNow)) == $past(faultNow)))
        else $error("fault flag lost a set");

endmodule // cdr_fault_flags

/* rtl/cdr_regs.sv */
// Control and status register bank of the coil current driver
`timescale 1ns/1ps
module cdr_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access from the serial engine
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Fault pins from the analog side
    input wire logic [cdr_pkg::FAULT_COUNT-1:0] faultPin,
    // Driver controls
    output logic [cdr_pkg::CODE_W-1:0] driveCode,
    output logic [cdr_pkg::CURRENT_W-1:0] driveCurrentUa,
    output logic driveEnable,
    output logic ringEnable
);
    import cdr_pkg::*;

    typedef struct packed {
        cdr_mode_t mode;
        logic ringEn;
        logic [CUR_HIGH_W-1:0] curHigh;
        logic [CUR_LOW_W-1:0] curLow;
        logic [CODE_W-1:0] applied;
        logic [CURRENT_W-1:0] currentUa;
        logic driveOn;
        logic [7:0] rdData;
    } cdr_regs_state_t;

    cdr_regs_state_t s;
    cdr_regs_state_t next_s;

    logic [FAULT_COUNT-1:0] faultNow;
    logic [FAULT_COUNT-1:0] faultFlags;
    logic clearFlags;
    logic wrControl;
    logic wrHigh;
    logic wrLow;
    logic softReset;
    logic tripFault;
    logic thermalNow;

    // Fault pins are asynchronous to sys_clk
    cdr_sync #(
        .WIDTH(FAULT_COUNT)
    ) faultSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(faultPin),
        .syncOut(faultNow)
    );

    cdr_fault_flags faultHold (
        .sys_clk(sys_clk),
        .rst(rst),
        .faultNow(faultNow),
        .clearAll(clearFlags),
        .flags(faultFlags)
    );

    // Address decode; writes to the fault register fall through
    always_comb begin
        wrControl = regWrite && (regAddr == ADDR_CONTROL);
        wrHigh = regWrite && (regAddr == ADDR_CUR_HIGH);
        wrLow = regWrite && (regAddr == ADDR_CUR_LOW);
        softReset = wrControl && regWrData[CTRL_SOFT_RESET_BIT];
        thermalNow = faultNow[FLT_THERMAL];
        tripFault = faultNow[FLT_THERMAL] || faultNow[FLT_COIL_SHORT]
            || faultNow[FLT_COIL_OPEN];
    end

    always_comb begin
        next_s = s;
        clearFlags = 1'b0;

        // Only bit D1 of control is storable
        if (wrControl) begin
            next_s.ringEn = regWrData[CTRL_RING_EN_BIT];
        end

        // High byte is staged, not applied
        if (wrHigh) begin
            next_s.curHigh = regWrData[CUR_HIGH_W-1:0];
        end

        // Low byte commits the whole code, or zero while a thermal fault is present
        if (wrLow) begin
            next_s.curLow = regWrData;
            if (thermalNow) begin
                next_s.applied = RST_CODE;
            end else begin
                next_s.applied = {s.curHigh, regWrData};
            end
        end

        // In active mode, hard faults win over a write in the same cycle
        if ((s.mode == CDR_ACTIVE) && tripFault) begin
            next_s.applied = RST_CODE;
            next_s.curHigh = RST_CUR_HIGH;
            next_s.curLow = RST_CUR_LOW;
        end

        // Soft reset bit is never stored, so it reads back zero
        if (softReset) begin
            next_s.ringEn = RST_RING_EN;
            next_s.curHigh = RST_CUR_HIGH;
            next_s.curLow = RST_CUR_LOW;
            next_s.applied = RST_CODE;
            clearFlags = 1'b1;
        end

        // Mode follows the applied code
        if (next_s.applied != RST_CODE) begin
            next_s.mode = CDR_ACTIVE;
        end else begin
            next_s.mode = CDR_STANDBY;
        end

        if ((s.mode == CDR_STANDBY) && (next_s.mode == CDR_ACTIVE)) begin
            clearFlags = 1'b1;
        end

        next_s.driveOn = (next_s.mode == CDR_ACTIVE);
        next_s.currentUa = CURRENT_W'(next_s.applied) * STEP_UA;

        // Read data is captured one cycle after the request
        if (regRead) begin
            unique case (regAddr)
                ADDR_CONTROL: begin
                    next_s.rdData = {6'h00, s.ringEn, 1'b0};
                end
                ADDR_CUR_HIGH: begin
                    next_s.rdData = {6'h00, s.curHigh};
                end
                ADDR_CUR_LOW: begin
                    next_s.rdData = s.curLow;
                end
                ADDR_FAULT: begin
                    next_s.rdData = {3'h0, faultFlags};
                end
                default: begin
                    next_s.rdData = RST_READ;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s.mode <= CDR_STANDBY;
            s.ringEn <= RST_RING_EN;
            s.curHigh <= RST_CUR_HIGH;
            s.curLow <= RST_CUR_LOW;
            s.applied <= RST_CODE;
            s.currentUa <= '0;
            s.driveOn <= 1'b0;
            s.rdData <= RST_READ;
        end else begin
            s <= next_s;
        end
    end

    // Every output is a flop of the state
    assign regRdData = s.rdData;
    assign driveCode = s.applied;
    assign driveCurrentUa = s.currentUa;
    assign driveEnable = s.driveOn;
    assign ringEnable = s.ringEn;

    default clocking cdrClk @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_SOFT_RESET_DEFAULTS: assert property (
        softReset |=> ringEnable && (driveCode == '0) && !driveEnable
            && (s.curHigh == '0) && (s.curLow == '0))
        else $error("soft reset did not restore defaults");

    AST_SOFT_RESET_READS_ZERO: assert property (
        regRead && (regAddr == ADDR_CONTROL) |=> !regRdData[CTRL_SOFT_RESET_BIT])
        else $error("soft reset bit read back as one");

    AST_RING_EN_WRITE: assert property (
        wrControl && !softReset |=> ringEnable == $past(regWrData[CTRL_RING_EN_BIT]))
        else $error("ring enable not written");

    AST_CONTROL_UPPER_ZERO: assert property (
        regRead && (regAddr == ADDR_CONTROL) |=> regRdData[7:2] == 6'h00)
        else $error("control read-only bits not zero");

    AST_LOW_COMMITS: assert property (
        wrLow && !thermalNow && !tripFault && !softReset
            |=> driveCode == {$past(s.curHigh), $past(regWrData)})
        else $error("low byte write did not commit code");

    AST_HIGH_ONLY_HOLDS: assert property (
        wrHigh && !tripFault |=> $stable(driveCode))
        else $error("high byte write changed the output");

    AST_STANDBY_IFF_ZERO: assert property (
        driveEnable == (driveCode != '0))
        else $error("mode disagrees with code");

    AST_CURRENT_SCALE: assert property (
        driveCurrentUa == CURRENT_W'(driveCode) * STEP_UA)
        else $error("current not 0.1 mA per step");

    AST_FAULT_DROPS: assert property (
        driveEnable && tripFault |=> !driveEnable && (driveCode == '0))
        else $error("hard fault did not clear the code");

    AST_THERMAL_LOCKOUT: assert property (
        thermalNow |=> !driveEnable)
        else $error("active while thermal fault present");

    AST_FAULT_READ: assert property (
        regRead && (regAddr == ADDR_FAULT) |=> regRdData == {3'h0, $past(faultFlags)})
        else $error("fault register read mismatch");

    AST_RING_READBACK: assert property (
        regRead && (regAddr == ADDR_CONTROL)
            |=> regRdData[CTRL_RING_EN_BIT] == $past(ringEnable))
        else $error("ring enable read back wrong");

    AST_RING_HOLDS: assert property (
        !wrControl |=> $stable(ringEnable))
        else $error("ring enable moved without a control write");

    AST_HIGH_READBACK: assert property (
        regRead && (regAddr == ADDR_CUR_HIGH) |=> regRdData == {6'h00, $past(s.curHigh)})
        else $error("high current bits read back wrong");

    AST_LOW_READBACK: assert property (
        regRead && (regAddr == ADDR_CUR_LOW) |=> regRdData == $past(s.curLow))
        else $error("low current bits read back wrong");

    AST_HIGH_STORED: assert property (
        wrHigh && !(driveEnable && tripFault)
            |=> s.curHigh == $past(regWrData[CUR_HIGH_W-1:0]))
        else $error("high current bits not stored");

    AST_LOW_STORED: assert property (
        wrLow && !(driveEnable && tripFault) |=> s.curLow == $past(regWrData))
        else $error("low current bits not stored");

    AST_HIGH_HOLDS: assert property (
        !wrHigh && !softReset && !(driveEnable && tripFault) |=> $stable(s.curHigh))
        else $error("high current bits moved without a write");

    AST_CODE_ONLY_ON_LOW: assert property (
        !wrLow && !softReset && !(driveEnable && tripFault) |=> $stable(driveCode))
        else $error("code changed without a low byte write");

    AST_ZERO_CODE_STANDBY: assert property (
        wrLow && !thermalNow && ({s.curHigh, regWrData} == '0) |=> !driveEnable)
        else $error("zero code left the output stage on");

    AST_THERMAL_REFUSE: assert property (
        wrLow && thermalNow |=> (driveCode == '0) && !driveEnable)
        else $error("low write activated during thermal fault");

    AST_FAULT_CLEARS_REGS: assert property (
        driveEnable && tripFault |=> (s.curHigh == '0) && (s.curLow == '0))
        else $error("hard fault left current bits set");

    AST_MINOR_FAULT_KEEPS: assert property (
        driveEnable && !tripFault && !softReset && !wrLow |=> driveEnable)
        else $error("output stage dropped without a hard fault");

    AST_FLAGS_CLEAR_ON_ACTIVATE: assert property (
        $rose(driveEnable) |-> faultFlags == $past(faultNow))
        else $error("flags kept past activation");

    AST_SOFT_RESET_FLAGS: assert property (
        softReset |=> faultFlags == $past(faultNow))
        else $error("soft reset did not clear fault flags");

    AST_UNMAPPED_READ: assert property (
        regRead && (regAddr != ADDR_CONTROL) && (regAddr != ADDR_CUR_HIGH)
            && (regAddr != ADDR_CUR_LOW) && (regAddr != ADDR_FAULT) |=> regRdData == RST_READ)
        else $error("unmapped read not zero");

    AST_FAULT_WRITE_IGNORED: assert property (
        regWrite && (regAddr == ADDR_FAULT) && !(driveEnable && tripFault)
            |=> $stable(driveCode) && $stable(ringEnable) && $stable(s.curLow))
        else $error("write to fault register changed state");

    COV_SOFT_RESET: cover property (driveEnable ##1 softReset ##1 !driveEnable);
    COV_ACTIVATE: cover property (wrHigh ##[1:4] wrLow ##1 driveEnable);
    COV_FAULT_DROP: cover property (driveEnable && tripFault ##1 !driveEnable);
    COV_THERMAL_REFUSE: cover property (wrLow && thermalNow && (regWrData != 8'h00));
    COV_RING_OFF: cover property (wrControl && !regWrData[CTRL_RING_EN_BIT] ##1 !ringEnable);

endmodule // cdr_regs

/* tb/cdr_host_model.sv */
// Host model issuing register strobes to the coil driver bank
`timescale 1ns/1ps
module cdr_host_model (
    // Clock
    input wire logic sys_clk,
    // Register strobes
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWrData,
    output logic regRead
);
    import cdr_pkg::*;
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWrData = 8'h00;
        regRead = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge sys_clk) #1;
        regWrite = 1'b0;
        regWrData = ~d; // Stale data must not be trusted
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk) #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge sys_clk) #1;
        regRead = 1'b0;
        regAddr = ~a;
    endtask
    // High part only stages, so the low write goes last
    task automatic setCode(input logic [CODE_W-1:0] c);
        wr(ADDR_CUR_HIGH, {6'h00, c[9:8]});
        wr(ADDR_CUR_LOW, c[7:0]);
    endtask
endmodule // cdr_host_model

/* tb/coil_driver_control_status_regs_test.sv */
// Self-checking bench for the coil driver register bank
`timescale 1ns/1ps
module coil_driver_control_status_regs_test;
    import cdr_pkg::*;
    logic sys_clk;
    logic rst;
    logic [7:0] regAddr;
    logic regWrite;
    logic [7:0] regWrData;
    logic regRead;
    logic [7:0] regRdData;
    logic [FAULT_COUNT-1:0] faultPin;
    logic [CODE_W-1:0] driveCode;
    logic [CURRENT_W-1:0] driveCurrentUa;
    logic driveEnable;
    logic ringEnable;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 41;
    logic [7:0] expQ[$];
    logic rdSeen = 1'b0;
    logic [CODE_W-1:0] rc;

    cdr_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead));
    cdr_regs dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
        .faultPin(faultPin), .driveCode(driveCode), .driveCurrentUa(driveCurrentUa),
        .driveEnable(driveEnable), .ringEnable(ringEnable));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        if (expQ.size() != 0) begin
            mismatches++;
        end
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkDrv(input logic [CODE_W-1:0] c, input logic en);
        logic [CURRENT_W-1:0] ua;
        ua = CURRENT_W'(c) * STEP_UA;
        num_checks++;
        if (driveCode !== c || driveCurrentUa !== ua || driveEnable !== en) begin
            mismatches++;
            $display("Error at %0t: got %h %h %h expected %h %h %h", $time, driveCode,
                driveCurrentUa, driveEnable, c, ua, en);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask

    // Read answers land one edge after the strobe; look mid-cycle
    always @(posedge sys_clk) begin
        rdSeen <= regRead;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    always @(negedge sys_clk) begin
        if (rdSeen) begin
            if (expQ.size() == 0) begin
                mismatches++;
                $display("Error at %0t: got %h with no expected value", $time, regRdData);
            end else begin
                cmp8(regRdData, expQ.pop_front());
            end
        end
    end

    initial begin
        rst = 1'b1;
        faultPin = 5'h00;
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        rdChk(ADDR_CONTROL, 8'h02);
        rdChk(ADDR_CUR_HIGH, 8'h00);
        rdChk(ADDR_CUR_LOW, 8'h00);
        rdChk(ADDR_FAULT, 8'h00);
        rdChk(8'h01, 8'h00);
        chkDrv(10'h000, 1'b0);
        $display("Test defaults done");
        host.wr(ADDR_CUR_HIGH, 8'hfd);
        chkDrv(10'h000, 1'b0);
        rdChk(ADDR_CUR_HIGH, 8'h01);
        host.wr(ADDR_CUR_LOW, 8'h55);
        chkDrv(10'h155, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rc = (i == 0) ? 10'h3ff : 10'($random(seed));
            host.setCode(rc);
            chkDrv(rc, rc != 10'h000);
        end
        $display("Test current code done");
        host.wr(ADDR_FAULT, 8'hff);
        rdChk(ADDR_FAULT, 8'h00);
        host.wr(ADDR_CONTROL, 8'hfc);
        rdChk(ADDR_CONTROL, 8'h00);
        cmp8({7'h00, ringEnable}, 8'h00);
        host.setCode(10'h2a5);
        host.wr(ADDR_CONTROL, 8'h01);
        chkDrv(10'h000, 1'b0);
        cmp8({7'h00, ringEnable}, 8'h01);
        rdChk(ADDR_CONTROL, 8'h02);
        rdChk(ADDR_CUR_LOW, 8'h00);
        $display("Test control done");
        for (int i = 0; i < FAULT_COUNT; i++) begin
            host.setCode(10'h000);
            host.setCode(10'h101 + 10'(i));
            rdChk(ADDR_FAULT, 8'h00);
            faultPin[i] = 1'b1;
            repeat (5) @(posedge sys_clk);
            #1 faultPin[i] = 1'b0;
            repeat (3) @(posedge sys_clk);
            rdChk(ADDR_FAULT, 8'h01 << i);
            chkDrv((i < 2) ? 10'h101 + 10'(i) : 10'h000, i < 2);
        end
        faultPin[FLT_THERMAL] = 1'b1;
        repeat (4) @(posedge sys_clk);
        host.setCode(10'h077);
        chkDrv(10'h000, 1'b0);
        faultPin[FLT_THERMAL] = 1'b0;
        repeat (4) @(posedge sys_clk);
        host.wr(ADDR_CUR_LOW, 8'h77);
        chkDrv(10'h077, 1'b1);
        rdChk(ADDR_FAULT, 8'h00);
        $display("Test faults done");
        host.wr(ADDR_CONTROL, 8'h00);
        faultPin[FLT_OVERCURRENT] = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 faultPin[FLT_OVERCURRENT] = 1'b0;
        rdChk(ADDR_FAULT, 8'h01);
        chkDrv(10'h077, 1'b1);
        // Let the pending read compare before reset wipes it
        @(posedge sys_clk);
        #1 rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        chkDrv(10'h000, 1'b0);
        cmp8({7'h00, ringEnable}, 8'h01);
        rdChk(ADDR_FAULT, 8'h00);
        rdChk(ADDR_CUR_LOW, 8'h00);
        $display("Test mid-run reset done");
        repeat (2) @(posedge sys_clk);
        stop_test();
    end
endmodule // coil_driver_control_status_regs_test
